/* File: inc/smsp_consts.vh */
// Register offsets, field positions, reset values and encodings for the serial port
`ifndef SMSP_CONSTS_VH
`define SMSP_CONSTS_VH

// Register offsets (word index on the plain register port)
`define SMSP_ADDR_CTRL 4'h0
`define SMSP_ADDR_DATA 4'h1
`define SMSP_ADDR_CFG 4'h2
`define SMSP_ADDR_RATE 4'h3

// Control register fields
`define SMSP_CTRL_TCF 7
`define SMSP_CTRL_WCF 6
`define SMSP_CTRL_MFF 5
`define SMSP_CTRL_ROF 4
`define SMSP_CTRL_SMH 3
`define SMSP_CTRL_SML 2
`define SMSP_CTRL_TBE 1
`define SMSP_CTRL_PEN 0

// Configuration register fields
`define SMSP_CFG_BUSY 7
`define SMSP_CFG_MEN 6
`define SMSP_CFG_SLSEL 3
`define SMSP_CFG_SELIN 2
`define SMSP_CFG_SRE 1
`define SMSP_CFG_RBE 0

// Reset values
`define SMSP_CTRL_RESET 8'h06
`define SMSP_CFG_RESET 8'h07
`define SMSP_RATE_RESET 8'h00

// Select mode encodings
`define SMSP_SM_3WIRE 2'h0
`define SMSP_SM_MULTI 2'h1

// Bits per byte
`define SMSP_BITS 4'h8

`endif

/* File: design/smsp_sync2.v */
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/10ps
module smsp_sync2 #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire sys_clk,
    input wire arst_n,
    // Data
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage1_reg;

    // First stage is read only by the second stage
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1_reg <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            stage1_reg <= async_in;
            sync_out <= stage1_reg;
        end
    end

endmodule // smsp_sync2

/* File: design/smsp_port.v */
// Byte-wide serial port, master or slave, with register access
`timescale 1ns/10ps
`include "smsp_consts.vh"

// Summary of operation
// - Bytes shift most significant bit first on both data lines.
// - Master drives master-out from top bit of the shift register.
// - Master-in floats when disabled or unselected 4-wire slave; 3-wire slave drives it.
// - 4-wire slave ignores serial clock while select input is high.
// - Select mode 00 three-wire, 01 select input, 1x select output.
// - Single-master 4-wire mode drives select pin with the mode low bit.
// - Master data write fills transmit buffer; empty shifter loads and starts.
// - Master shifts out while clocking and captures master-in into same register.
// - Master moves finished byte to receive buffer; data reads return it.
// - Every finished byte sets the transfer complete flag.
// - Master in multi-master mode with select low clears master and port enables, sets mode fault.
// - Enabled with master enable clear acts as slave, shifting on external clock.
// - Slave counts clock edges; after 8 bits sets flag and copies byte.
// - Slave data writes go via transmit buffer, loading shifter at once if empty.
// - Occupied slave shifter reloads from transmit buffer after a transfer's last sample edge.
// - 4-wire slave active while select low; bit counter resets on select fall.
// - 3-wire slave counter resets only by toggling the port enable bit.
// - Data write with full transmit buffer sets collision flag and is discarded.
// - Slave completion with unread receive byte sets overrun and drops new byte.
// - The four flags are set by hardware and cleared only by software.
module smsp_port #(
    parameter DIV_WIDTH = 8
) (
    // Clock and reset
    input wire sys_clk,
    input wire arst_n,
    // Register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Serial clock pin
    input wire sclk_in,
    output reg sclk_out,
    output reg sclk_oe,
    // Master-out pin
    input wire mosi_in,
    output reg mosi_out,
    output reg mosi_oe,
    // Master-in pin
    input wire miso_in,
    output reg miso_out,
    output reg miso_oe,
    // Select pin
    input wire slave_select_line_in,
    output reg slave_select_line_out,
    output reg slave_select_line_oe,
    // Transfer complete level for an outside interrupt controller
    output reg transfer_complete_flag
);

    // Control bits
    reg write_collision_flag;
    reg mode_fault_flag;
    reg receive_overrun_flag;
    reg select_mode_high_bit;
    reg select_mode_low_bit;
    reg port_enable_bit;
    reg master_enable_bit;
    reg clk_pol_reg;
    reg clk_pha_reg;
    reg [7:0] rate_reg;
    // Data path
    reg [7:0] shift_reg;
    reg [7:0] tx_buf_reg;
    reg tx_full_reg;
    reg [7:0] rx_buf_reg;
    reg rx_full_reg;
    reg shift_full_reg;
    reg [3:0] bit_cnt_reg;
    reg busy_reg;
    // Master timing
    reg [DIV_WIDTH-1:0] div_cnt_reg;
    reg mst_phase_reg;
    // Slave edge detection
    reg sclk_d_reg;
    reg sel_d_reg;
    reg [3:0] nxt_cnt;

    wire [2:0] pins_sync;
    wire sclk_s;
    wire mosi_s;
    wire miso_s;
    wire sel_n_s;
    wire sel_act_s;

    // Every pin input passes two flops before use
    smsp_sync2 #(
        .WIDTH(3)
    ) u_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .async_in({sclk_in, mosi_in, miso_in}),
        .sync_out(pins_sync)
    );

    smsp_sync2 #(
        .WIDTH(1)
    ) u_sync_sel (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .async_in(!slave_select_line_in),
        .sync_out(sel_act_s)
    );

    // Select travels inverted so it leaves reset at its idle high level, no false fall
    assign sel_n_s = !sel_act_s;

    assign sclk_s = pins_sync[2];
    assign mosi_s = pins_sync[1];
    assign miso_s = pins_sync[0];

    // Mode decode
    wire mode_3w = ({select_mode_high_bit, select_mode_low_bit} == `SMSP_SM_3WIRE);
    wire mode_mm = ({select_mode_high_bit, select_mode_low_bit} == `SMSP_SM_MULTI);
    wire is_master = port_enable_bit && master_enable_bit;
    wire is_slave = port_enable_bit && !master_enable_bit;
    // Three-wire slave is always selected; four-wire needs select low
    wire slv_sel = mode_3w || !sel_n_s;
    wire slv_act = is_slave && slv_sel;
    // Polarity-corrected serial clock, rising means leading edge
    wire sck_lvl = sclk_s ^ clk_pol_reg;
    wire sck_prev = sclk_d_reg ^ clk_pol_reg;
    wire lead_edge = sck_lvl && !sck_prev;
    wire trail_edge = !sck_lvl && sck_prev;
    // Sample on the first edge with phase 0, second with phase 1
    wire smp_edge = clk_pha_reg ? trail_edge : lead_edge;
    wire drv_edge = clk_pha_reg ? lead_edge : trail_edge;
    wire sel_fall = sel_d_reg && !sel_n_s;

    // Data write and collision decode
    wire data_wr = reg_wr && (reg_addr == `SMSP_ADDR_DATA);
    wire data_rd = reg_rd && (reg_addr == `SMSP_ADDR_DATA);
    wire ctrl_wr = reg_wr && (reg_addr == `SMSP_ADDR_CTRL);
    wire cfg_wr = reg_wr && (reg_addr == `SMSP_ADDR_CFG);
    wire wr_accept = data_wr && !tx_full_reg;
    wire wr_collide = data_wr && tx_full_reg;
    wire mode_fault = is_master && mode_mm && !sel_n_s;
    wire tick = (div_cnt_reg == {DIV_WIDTH{1'b0}});

    // Byte completion events
    wire mst_done = is_master && busy_reg && tick && mst_phase_reg && (bit_cnt_reg == `SMSP_BITS - 4'h1);
    wire slv_done = slv_act && smp_edge && (bit_cnt_reg == `SMSP_BITS - 4'h1);
    wire byte_done = mst_done || slv_done;

    // Delayed copies for edge detection
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_d_reg <= 1'b0;
            sel_d_reg <= 1'b1;
        end else begin
            sclk_d_reg <= sclk_s;
            sel_d_reg <= sel_n_s;
        end
    end

    // Control register and flags; hardware set wins over software clear
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            transfer_complete_flag <= 1'b0;
            write_collision_flag <= 1'b0;
            mode_fault_flag <= 1'b0;
            receive_overrun_flag <= 1'b0;
            select_mode_high_bit <= 1'b0;
            select_mode_low_bit <= 1'b1;
            port_enable_bit <= 1'b0;
            master_enable_bit <= 1'b0;
            clk_pol_reg <= 1'b0;
            clk_pha_reg <= 1'b0;
            rate_reg <= `SMSP_RATE_RESET;
        end else begin
            if (ctrl_wr) begin
                transfer_complete_flag <= reg_wdata[`SMSP_CTRL_TCF];
                write_collision_flag <= reg_wdata[`SMSP_CTRL_WCF];
                mode_fault_flag <= reg_wdata[`SMSP_CTRL_MFF];
                receive_overrun_flag <= reg_wdata[`SMSP_CTRL_ROF];
                select_mode_high_bit <= reg_wdata[`SMSP_CTRL_SMH];
                select_mode_low_bit <= reg_wdata[`SMSP_CTRL_SML];
                port_enable_bit <= reg_wdata[`SMSP_CTRL_PEN];
            end
            if (cfg_wr) begin
                master_enable_bit <= reg_wdata[`SMSP_CFG_MEN];
                clk_pha_reg <= reg_wdata[5];
                clk_pol_reg <= reg_wdata[4];
            end
            if (reg_wr && (reg_addr == `SMSP_ADDR_RATE)) begin
                rate_reg <= reg_wdata;
            end
            // Hardware sets after software writes so they win
            if (byte_done) begin
                transfer_complete_flag <= 1'b1;
            end
            if (wr_collide) begin
                write_collision_flag <= 1'b1;
            end
            if (slv_done && rx_full_reg && !data_rd) begin
                receive_overrun_flag <= 1'b1;
            end
            if (mode_fault) begin
                mode_fault_flag <= 1'b1;
                master_enable_bit <= 1'b0;
                port_enable_bit <= 1'b0;
            end
        end
    end

    // Next bit count for a slave sample edge
    always @* begin
        nxt_cnt = bit_cnt_reg + 4'h1;
        if (bit_cnt_reg == `SMSP_BITS - 4'h1) begin
            nxt_cnt = 4'h0;
        end
    end

    // Shift register, buffers, counter and master clock generation
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            shift_reg <= 8'h00;
            tx_buf_reg <= 8'h00;
            tx_full_reg <= 1'b0;
            rx_buf_reg <= 8'h00;
            rx_full_reg <= 1'b0;
            shift_full_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            busy_reg <= 1'b0;
            div_cnt_reg <= {DIV_WIDTH{1'b0}};
            mst_phase_reg <= 1'b0;
        end else begin
            if (data_rd) begin
                rx_full_reg <= 1'b0;
            end
            if (wr_accept) begin
                tx_buf_reg <= reg_wdata;
                tx_full_reg <= 1'b1;
            end
            if (!port_enable_bit) begin
                // Disabling clears the counter; only way for a 3-wire slave
                bit_cnt_reg <= 4'h0;
                busy_reg <= 1'b0;
                mst_phase_reg <= 1'b0;
                shift_full_reg <= 1'b0;
            end else if (is_master) begin
                if (!busy_reg) begin
                    // Empty shifter takes the buffer and starts at once
                    if (tx_full_reg) begin
                        shift_reg <= tx_buf_reg;
                        tx_full_reg <= 1'b0;
                        busy_reg <= 1'b1;
                        bit_cnt_reg <= 4'h0;
                        mst_phase_reg <= 1'b0;
                        div_cnt_reg <= rate_reg[DIV_WIDTH-1:0];
                    end
                end else if (tick) begin
                    div_cnt_reg <= rate_reg[DIV_WIDTH-1:0];
                    mst_phase_reg <= !mst_phase_reg;
                    if (mst_phase_reg) begin
                        // End of bit: sample master-in into the freed low bit
                        shift_reg <= {shift_reg[6:0], miso_s};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (mst_done) begin
                            rx_buf_reg <= {shift_reg[6:0], miso_s};
                            rx_full_reg <= 1'b1;
                            busy_reg <= 1'b0;
                            bit_cnt_reg <= 4'h0;
                        end
                    end
                end else begin
                    div_cnt_reg <= div_cnt_reg - {{(DIV_WIDTH-1){1'b0}}, 1'b1};
                end
            end else begin
                // Slave: counter restarts on each select fall outside three-wire mode
                if (!mode_3w && sel_fall) begin
                    bit_cnt_reg <= 4'h0;
                end else if (slv_act && smp_edge) begin
                    shift_reg <= {shift_reg[6:0], mosi_s};
                    bit_cnt_reg <= nxt_cnt;
                    busy_reg <= 1'b1;
                    shift_full_reg <= 1'b0;
                    if (slv_done) begin
                        busy_reg <= 1'b0;
                        if (!rx_full_reg || data_rd) begin
                            rx_buf_reg <= {shift_reg[6:0], mosi_s};
                            rx_full_reg <= 1'b1;
                        end
                        // Reload on the last sample edge of the byte
                        if (tx_full_reg) begin
                            shift_reg <= tx_buf_reg;
                            tx_full_reg <= 1'b0;
                            shift_full_reg <= 1'b1;
                        end
                    end
                end else if (tx_full_reg && !shift_full_reg && !busy_reg) begin
                    shift_reg <= tx_buf_reg;
                    tx_full_reg <= 1'b0;
                    shift_full_reg <= 1'b1;
                end
            end
        end
    end

    // Pin drivers, all registered
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_out <= 1'b0;
            sclk_oe <= 1'b0;
            mosi_out <= 1'b0;
            mosi_oe <= 1'b0;
            miso_out <= 1'b0;
            miso_oe <= 1'b0;
            slave_select_line_out <= 1'b1;
            slave_select_line_oe <= 1'b0;
        end else begin
            // Master: clock toggles mid-bit per phase setting
            sclk_oe <= is_master;
            sclk_out <= clk_pol_reg ^ (busy_reg && (mst_phase_reg ^ clk_pha_reg));
            mosi_oe <= is_master;
            mosi_out <= shift_reg[7];
            // Slave output updates on driving edges, and every cycle while idle or not an active slave
            miso_oe <= is_slave && slv_sel;
            if (!slv_act || drv_edge || !busy_reg) begin
                miso_out <= shift_reg[7];
            end
            // Select output only in single-master 4-wire mode
            slave_select_line_oe <= select_mode_high_bit && port_enable_bit;
            slave_select_line_out <= select_mode_low_bit;
        end
    end

    // Register read data, one cycle after the strobe
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `SMSP_ADDR_CTRL: reg_rdata <= {transfer_complete_flag, write_collision_flag, mode_fault_flag,
                    receive_overrun_flag, select_mode_high_bit, select_mode_low_bit, !tx_full_reg, port_enable_bit};
                `SMSP_ADDR_DATA: reg_rdata <= rx_buf_reg;
                `SMSP_ADDR_CFG: reg_rdata <= {busy_reg, master_enable_bit, clk_pha_reg, clk_pol_reg,
                    slv_sel && !mode_3w, sel_n_s, is_master || !(shift_full_reg || busy_reg),
                    is_master || !rx_full_reg};
                `SMSP_ADDR_RATE: reg_rdata <= rate_reg;
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // smsp_port

/* File: sim/smsp_port_props.sv */
// Port-level assertions for the serial port
`timescale 1ns/10ps
module smsp_port_props (
    // Clock and reset
    input wire sys_clk,
    input wire arst_n,
    // Register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // Pin drives and select input
    input wire sclk_oe,
    input wire mosi_oe,
    input wire miso_oe,
    input wire slave_select_line_in,
    input wire slave_select_line_out,
    input wire slave_select_line_oe,
    input wire transfer_complete_flag
);
    reg [1:0] mode_reg;
    wire ctrl_wr = reg_wr && reg_addr == 4'h0;
    // Shadow of select mode; hardware never alters it
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            mode_reg <= 2'h1;
        else if (ctrl_wr)
            mode_reg <= reg_wdata[3:2];
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // Six raw cycles cover the two-flop sync plus register delay
    sequence s_sel_low;
        (mode_reg == 2'h1 && !slave_select_line_in) [*6];
    endsequence
    sequence s_sel_high;
        (mode_reg == 2'h1 && slave_select_line_in && !sclk_oe) [*6];
    endsequence
    sequence s_mode_still;
        mode_reg == $past(mode_reg) && mode_reg == $past(mode_reg, 2);
    endsequence
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    a_master_pair: assert property (mosi_oe == sclk_oe)
        else $error("master-out drive without clock drive");
    a_slave_noclk: assert property (miso_oe |-> !sclk_oe)
        else $error("slave drives the serial clock");
    a_miso_unsel: assert property (s_sel_high |-> !miso_oe)
        else $error("unselected slave drives master-in");
    a_fault_drop: assert property (s_sel_low |-> !sclk_oe)
        else $error("master kept bus with select low");
    a_sel_mode: assert property ((slave_select_line_oe and s_mode_still) |-> mode_reg[1])
        else $error("select driven outside output mode");
    a_sel_level: assert property ((slave_select_line_oe and s_mode_still) |-> slave_select_line_out == mode_reg[0])
        else $error("select level differs from mode low bit");
    a_flag_sticky: assert property ($fell(transfer_complete_flag) |->
        $past(ctrl_wr && !reg_wdata[7]) || $past(ctrl_wr && !reg_wdata[7], 2))
        else $error("complete flag cleared without software");
    a_unsel_quiet: assert property (s_sel_high |-> !$rose(transfer_complete_flag))
        else $error("transfer completed while unselected");
endmodule // smsp_port_props

/* File: sim/smsp_peer.sv */
// Behavioural far-side device: slave answering the port, or master driving it
`timescale 1ns/10ps
module smsp_peer (
    // Wire levels
    input wire sclk_w,
    input wire mosi_w,
    input wire miso_w,
    // Drives toward the port
    output reg p_sclk,
    output reg p_mosi,
    output wire p_miso,
    output reg p_sel
);
    reg slave_on = 1'b0;
    reg [2:0] cnt = 3'h0;
    reg [7:0] in_sh = 8'h00;
    reg [7:0] out_sh = 8'h00;
    reg [7:0] m_rx = 8'h00;
    reg [7:0] tx_q[$];
    reg [7:0] got_q[$];
    initial begin
        p_sclk = 1'b0;
        p_mosi = 1'b0;
        p_sel = 1'b1;
    end
    // Idle line shows a moving pattern, not the last bit
    assign p_miso = slave_on ? out_sh[7] : ~mosi_w;
    // Slave: sample on rising edge, next bit on falling edge
    always @(posedge sclk_w) begin
        if (slave_on) begin
            in_sh = {in_sh[6:0], mosi_w};
            cnt = cnt + 3'h1;
            if (cnt == 3'h0)
                got_q.push_back(in_sh);
        end
    end
    always @(negedge sclk_w) begin
        if (slave_on)
            out_sh = (cnt == 3'h0 && tx_q.size() > 0) ? tx_q.pop_front() : {out_sh[6:0], 1'b0};
    end
    task role(input on, input [7:0] b);
        begin
            slave_on = on;
            out_sh = b;
            cnt = 3'h0;
        end
    endtask
    task set_sel(input v);
        #3 p_sel = v;
    endtask
    // Master: n bits, 80 ns clock, select lowered 100 ns ahead
    task send(input [7:0] b, input integer n, input sel);
        integer i;
        begin
            // Gap keeps select from toggling twice at once; offset keeps pins off the clock edge
            #43 p_sel = !sel;
            #100;
            for (i = 0; i < n; i = i + 1) begin
                p_mosi = b[7 - i];
                #40 p_sclk = 1'b1;
                m_rx = {m_rx[6:0], miso_w};
                #40 p_sclk = 1'b0;
            end
            #40 p_sel = 1'b1;
            p_mosi = ~p_mosi;
        end
    endtask
endmodule // smsp_peer

/* File: sim/smsp_port_tb.sv */
// Self-checking bench for the serial port
`timescale 1ns/10ps
`include "smsp_consts.vh"
bind smsp_port smsp_port_props props_u (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk_oe(sclk_oe),
    .mosi_oe(mosi_oe), .miso_oe(miso_oe), .slave_select_line_in(slave_select_line_in),
    .slave_select_line_out(slave_select_line_out), .slave_select_line_oe(slave_select_line_oe),
    .transfer_complete_flag(transfer_complete_flag));
module smsp_port_tb;
    reg sys_clk = 1'b0;
    reg arst_n = 1'b0;
    reg [3:0] reg_addr = 4'h0;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    wire [7:0] reg_rdata;
    wire sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe, sel_out, sel_oe, tcf;
    wire p_sclk, p_mosi, p_miso, p_sel;
    integer bad_count = 0;
    integer tests_run = 0;
    // Wire levels from every party's enable
    wire sclk_w = sclk_oe ? sclk_out : p_sclk;
    wire mosi_w = mosi_oe ? mosi_out : p_mosi;
    wire miso_w = miso_oe ? miso_out : p_miso;
    wire sel_w = sel_oe ? sel_out : p_sel;
    smsp_port dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk_in(sclk_w), .sclk_out(sclk_out),
        .sclk_oe(sclk_oe), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
        .miso_out(miso_out), .miso_oe(miso_oe), .slave_select_line_in(sel_w), .slave_select_line_out(sel_out),
        .slave_select_line_oe(sel_oe), .transfer_complete_flag(tcf));
    smsp_peer peer_u (.sclk_w(sclk_w), .mosi_w(mosi_w), .miso_w(miso_w), .p_sclk(p_sclk), .p_mosi(p_mosi),
        .p_miso(p_miso), .p_sel(p_sel));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task stop_test;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, bad_count);
            if (bad_count == 0 && tests_run > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("BAD at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge sys_clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge sys_clk);
            reg_wr <= 1'b0;
        end
    endtask
    // Read data stand only in the cycle after the strobe
    task rd(input [3:0] a, input [7:0] m, input [7:0] exp);
        begin
            @(posedge sys_clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge sys_clk);
            reg_rd <= 1'b0;
            #1;
            chk(reg_rdata & m, exp);
        end
    endtask
    // Bounded wait, so a dead port cannot hang the run
    task wait_tcf;
        integer i;
        begin
            i = 0;
            while (tcf !== 1'b1 && i < 2000) begin
                @(posedge sys_clk);
                i = i + 1;
            end
            chk({7'h00, tcf}, 8'h01);
        end
    endtask
    initial begin
        #200000;
        bad_count = bad_count + 1;
        $display("BAD at %0t: watchdog expired", $time);
        stop_test;
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd(4'h0, 8'hFF, `SMSP_CTRL_RESET);
        rd(4'h2, 8'hFF, `SMSP_CFG_RESET);
        rd(4'h7, 8'hFF, 8'h00);
        chk({7'h00, miso_oe}, 8'h00);
        $display("test reset done");
        // Master in multi-master mode loses the bus
        wr(4'h2, 8'h40);
        wr(4'h0, 8'h05);
        peer_u.set_sel(1'b0);
        repeat (10) @(posedge sys_clk);
        rd(4'h0, 8'h21, 8'h20);
        rd(4'h2, 8'h40, 8'h00);
        peer_u.set_sel(1'b1);
        wr(4'h0, 8'h04);
        $display("test mode fault done");
        // Master, select output low, back-to-back writes and a collision
        peer_u.role(1'b1, 8'hA5);
        peer_u.tx_q.push_back(8'h5B);
        wr(4'h3, 8'h01);
        rd(4'h3, 8'hFF, 8'h01);
        wr(4'h2, 8'h40);
        wr(4'h0, 8'h09);
        wr(4'h1, 8'h3C);
        wr(4'h1, 8'h5A);
        wr(4'h1, 8'h77);
        chk({7'h00, sel_w}, 8'h00);
        rd(4'h0, 8'h40, 8'h40);
        wait_tcf;
        rd(4'h1, 8'hFF, 8'hA5);
        repeat (60) @(posedge sys_clk);
        rd(4'h0, 8'h80, 8'h80);
        rd(4'h1, 8'hFF, 8'h5B);
        chk(peer_u.got_q.size(), 8'h02);
        chk(peer_u.got_q[0], 8'h3C);
        chk(peer_u.got_q[1], 8'h5A);
        wr(4'h0, 8'h09);
        rd(4'h0, 8'hC0, 8'h00);
        $display("test master done");
        // Four-wire slave: preload, reload, overrun, unselected burst
        peer_u.role(1'b0, 8'h00);
        wr(4'h2, 8'h00);
        wr(4'h0, 8'h05);
        wr(4'h1, 8'hC3);
        wr(4'h1, 8'h3A);
        peer_u.send(8'h96, 8, 1'b1);
        wait_tcf;
        chk(peer_u.m_rx, 8'hC3);
        peer_u.send(8'h21, 8, 1'b1);
        chk(peer_u.m_rx, 8'h3A);
        repeat (10) @(posedge sys_clk);
        rd(4'h0, 8'h10, 8'h10);
        rd(4'h1, 8'hFF, 8'h96);
        wr(4'h0, 8'h05);
        peer_u.send(8'h44, 8, 1'b0);
        repeat (10) @(posedge sys_clk);
        rd(4'h0, 8'h80, 8'h00);
        $display("test slave done");
        // Three-wire slave: partial byte dropped by toggling enable
        wr(4'h0, 8'h01);
        repeat (4) @(posedge sys_clk);
        chk({7'h00, miso_oe}, 8'h01);
        peer_u.send(8'hF0, 4, 1'b0);
        wr(4'h0, 8'h00);
        wr(4'h0, 8'h01);
        peer_u.send(8'h6D, 8, 1'b0);
        wait_tcf;
        rd(4'h1, 8'hFF, 8'h6D);
        $display("test three-wire done");
        stop_test;
    end
endmodule // smsp_port_tb
